// ---- rtl/psci_top.sv ----
// Control, output and interrupt pad logic of the pressure sensor
module psci_top #(
  parameter int PER_1HZ = psci_pkg::PER_1HZ_CYC,
  parameter int PER_7HZ = psci_pkg::PER_7HZ_CYC,
  parameter int PER_12HZ5 = psci_pkg::PER_12HZ5_CYC,
  parameter int PER_25HZ = psci_pkg::PER_25HZ_CYC
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // Serial link
  input wire logic spi_cs_b,
  input wire logic spi_clk,
  input wire logic shared_serial_pin_in,
  output logic shared_serial_pin_out,
  output logic shared_serial_pin_oe,
  output logic serial_out_pin,
  output logic serial_out_pin_oe,
  // Sensor front end and trim store
  input wire logic [23:0] sensor_press,
  input wire logic [15:0] sensor_temp,
  input wire logic [15:0] trim_store,
  output logic [15:0] calib_trim,
  output logic power_active,
  // Interrupt pads
  output logic first_irq_pad_out,
  output logic first_irq_pad_oe,
  output logic second_irq_pad_out,
  output logic second_irq_pad_oe
);
  import psci_pkg::*;

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_b);

  psci_ctrl1_type ctrl1_reg;
  psci_ctrl2_type ctrl2_reg;
  psci_ctrl3_type ctrl3_reg;
  psci_evcfg_type evcfg_reg;
  psci_spi_state_type state_reg;
  logic cs_s1_reg, cs_s2_reg, ck_s1_reg, ck_s2_reg, ck_s3_reg;
  logic di_s1_reg, di_s2_reg, ck_rise, ck_fall, byte_done;
  logic [2:0] bit_cnt_reg;
  logic [7:0] sh_reg, tx_reg, dout_reg, byte_in, rd_dat;
  logic [6:0] addr_reg, addr_next, rd_adr;
  logic ms_reg, wr_stb, rd_stb, sw_rst, boot_done, init_reg;
  logic [23:0] ref_reg, ofs_reg, pout_reg, comp, pout_next, diff;
  logic [15:0] ths_reg, tout_reg;
  logic [1:0] tick, pad_out_reg, pad_oe_reg;
  logic p_new, t_new, oneshot_mode, conv_go, eval, above, below;
  logic az_pend_reg, az_reg, pda_reg, tda_reg, por_reg, tor_reg;
  logic [2:0] isrc_reg, evv, pmask_reg, pmask_next;
  logic [1:0] tmask_reg, tmask_next;
  logic rd_ph, rd_th, rd_isrc, rd_take, plock, tlock;
  logic [25:0] diffx, thx;

  //----------------------------------------------------------------------
  // Link synchronisers
  //----------------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      cs_s1_reg <= 1'b1;
      cs_s2_reg <= 1'b1;
      ck_s1_reg <= 1'b1;
      ck_s2_reg <= 1'b1;
      ck_s3_reg <= 1'b1;
      di_s1_reg <= 1'b0;
      di_s2_reg <= 1'b0;
    end
    else
    begin
      cs_s1_reg <= spi_cs_b;
      cs_s2_reg <= cs_s1_reg;
      ck_s1_reg <= spi_clk;
      ck_s2_reg <= ck_s1_reg;
      ck_s3_reg <= ck_s2_reg;
      di_s1_reg <= shared_serial_pin_in;
      di_s2_reg <= di_s1_reg;
    end
  end

  //----------------------------------------------------------------------
  // Serial register access
  //----------------------------------------------------------------------
  assign ck_rise = ck_s2_reg && !ck_s3_reg;
  assign ck_fall = !ck_s2_reg && ck_s3_reg;
  assign byte_in = {sh_reg[6:0], di_s2_reg};
  assign byte_done = ck_rise && bit_cnt_reg == 3'd7 && !cs_s2_reg;
  assign addr_next = addr_reg + {6'h00, ms_reg};
  assign wr_stb = byte_done && state_reg == SPI_WR;
  assign rd_stb = byte_done &&
    ((state_reg == SPI_CMD && byte_in[7]) || state_reg == SPI_RD);
  assign rd_adr = (state_reg == SPI_CMD) ? {1'b0, byte_in[5:0]} : addr_next;

  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state_reg <= SPI_IDLE;
      bit_cnt_reg <= 3'h0;
      sh_reg <= 8'h00;
      addr_reg <= 7'h00;
      ms_reg <= 1'b0;
      tx_reg <= 8'h00;
      dout_reg <= 8'h00;
    end
    else if (cs_s2_reg)
    begin
      state_reg <= SPI_IDLE;
      bit_cnt_reg <= 3'h0;
    end
    else
    begin
      if (state_reg == SPI_IDLE)
        state_reg <= SPI_CMD;
      if (ck_rise)
      begin
        sh_reg <= byte_in;
        bit_cnt_reg <= bit_cnt_reg + 3'd1;
      end
      if (byte_done)
      begin
        case (state_reg)
          SPI_CMD: state_reg <= byte_in[7] ? SPI_RD : SPI_WR;
          SPI_WR: state_reg <= SPI_WR;
          SPI_RD: state_reg <= SPI_RD;
          default: state_reg <= SPI_IDLE;
        endcase
        if (state_reg == SPI_CMD)
          ms_reg <= byte_in[6];
        addr_reg <= (state_reg == SPI_WR) ? addr_next : rd_adr;
        tx_reg <= rd_dat;
      end
      if (ck_fall && state_reg == SPI_RD)
        dout_reg <= {7'h00, tx_reg[3'd7 - bit_cnt_reg]};
    end
  end

  assign serial_out_pin = dout_reg[0];
  assign shared_serial_pin_out = dout_reg[0];
  assign serial_out_pin_oe = state_reg == SPI_RD && !cs_s2_reg &&
    !ctrl1_reg.three_wire_select;
  assign shared_serial_pin_oe = state_reg == SPI_RD && !cs_s2_reg &&
    ctrl1_reg.three_wire_select;

  always_comb
  begin
    case (rd_adr)
      ADR_REF_XL: rd_dat = ref_reg[7:0];
      ADR_REF_L: rd_dat = ref_reg[15:8];
      ADR_REF_H: rd_dat = ref_reg[23:16];
      ADR_ID: rd_dat = ID_VALUE;
      ADR_CTRL1: rd_dat = ctrl1_reg;
      ADR_CTRL2: rd_dat = ctrl2_reg;
      ADR_CTRL3: rd_dat = ctrl3_reg;
      ADR_EVCFG: rd_dat = evcfg_reg;
      ADR_ISRC: rd_dat = {5'h00, isrc_reg};
      ADR_THS_L: rd_dat = ths_reg[7:0];
      ADR_THS_H: rd_dat = ths_reg[15:8];
      ADR_STATUS: rd_dat = {2'h0, por_reg, tor_reg, 2'h0, pda_reg, tda_reg};
      ADR_POUT_XL: rd_dat = pout_reg[7:0];
      ADR_POUT_L: rd_dat = pout_reg[15:8];
      ADR_POUT_H: rd_dat = pout_reg[23:16];
      ADR_TOUT_L: rd_dat = tout_reg[7:0];
      ADR_TOUT_H: rd_dat = tout_reg[15:8];
      ADR_OFS_XL: rd_dat = ofs_reg[7:0];
      ADR_OFS_L: rd_dat = ofs_reg[15:8];
      ADR_OFS_H: rd_dat = ofs_reg[23:16];
      default: rd_dat = 8'h00;
    endcase
  end

  //----------------------------------------------------------------------
  // Rate ticks
  //----------------------------------------------------------------------
  function automatic logic [31:0] rate_cycles(input logic [2:0] r,
                                              input logic temp);
    case (r)
      3'h1: rate_cycles = 32'(PER_1HZ);
      3'h2: rate_cycles = temp ? 32'(PER_1HZ) : 32'(PER_7HZ);
      3'h3: rate_cycles = temp ? 32'(PER_1HZ) : 32'(PER_12HZ5);
      3'h4: rate_cycles = temp ? 32'(PER_1HZ) : 32'(PER_25HZ);
      3'h5: rate_cycles = 32'(PER_7HZ);
      3'h6: rate_cycles = 32'(PER_12HZ5);
      default: rate_cycles = 32'(PER_25HZ);
    endcase
  endfunction

  for (genvar i = 0; i < 2; i++)
  begin : g_tick
    logic [31:0] cnt_reg;
    logic [31:0] per;
    assign per = rate_cycles(ctrl1_reg.sample_rate_sel, i == 1);
    assign tick[i] = cnt_reg >= per - 32'd1;
    always_ff @(posedge core_clk or negedge rst_b)
    begin
      if (!rst_b)
        cnt_reg <= 32'h0;
      else if (tick[i])
        cnt_reg <= 32'h0;
      else
        cnt_reg <= cnt_reg + 32'd1;
    end
  end

  //----------------------------------------------------------------------
  // Conversion and pressure arithmetic
  //----------------------------------------------------------------------
  assign oneshot_mode = ctrl1_reg.sample_rate_sel == RATE_ONE_SHOT;
  assign conv_go = ctrl1_reg.power_active_bit &&
    (!oneshot_mode || ctrl2_reg.one_shot);
  assign p_new = conv_go && tick[0];
  assign t_new = conv_go && (oneshot_mode ? tick[0] : tick[1]);
  assign comp = sensor_press +
    (ctrl1_reg.offset_enable ? ofs_reg : 24'h0);
  assign pout_next = az_reg ? comp - ref_reg : comp + ref_reg;
  assign diff = comp - ref_reg;
  assign diffx = {{2{diff[23]}}, diff};
  assign thx = {2'h0, ths_reg, 8'h00};
  assign above = $signed(diffx) > $signed(thx);
  assign below = $signed(diffx) < -$signed(thx);
  assign eval = p_new && ctrl1_reg.differential_enable;
  assign evv[0] = above && evcfg_reg.high_event_enable;
  assign evv[1] = below && evcfg_reg.low_event_enable;
  assign evv[2] = evv[0] || evv[1];
  assign boot_done = ctrl2_reg.reload_req && tick[0];
  assign sw_rst = boot_done && ctrl2_reg.soft_reset_req;
  // Side effects once a byte starts to leave, never on a dropped prefetch
  assign rd_take = ck_fall && state_reg == SPI_RD && bit_cnt_reg == 3'd0 &&
    !cs_s2_reg;
  assign rd_ph = rd_take && addr_reg == ADR_POUT_H;
  assign rd_th = rd_take && addr_reg == ADR_TOUT_H;
  assign rd_isrc = rd_take && addr_reg == ADR_ISRC;
  assign plock = ctrl1_reg.block_update && pmask_reg != 3'h0;
  assign tlock = ctrl1_reg.block_update && tmask_reg != 2'h0;

  always_comb
  begin
    pmask_next = pmask_reg;
    tmask_next = tmask_reg;
    if (rd_take && addr_reg == ADR_POUT_XL)
      pmask_next[0] = 1'b1;
    if (rd_take && addr_reg == ADR_POUT_L)
      pmask_next[1] = 1'b1;
    if (rd_ph)
      pmask_next[2] = 1'b1;
    if (rd_take && addr_reg == ADR_TOUT_L)
      tmask_next[0] = 1'b1;
    if (rd_th)
      tmask_next[1] = 1'b1;
    if (pmask_next == 3'h7)
      pmask_next = 3'h0;
    if (tmask_next == 2'h3)
      tmask_next = 2'h0;
  end

  //----------------------------------------------------------------------
  // Control registers
  //----------------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      ctrl1_reg <= CTRL_RST;
      ctrl2_reg <= CTRL_RST;
      ctrl3_reg <= CTRL_RST;
      evcfg_reg <= EVCFG_RST;
    end
    else if (sw_rst)
    begin
      ctrl1_reg <= CTRL_RST;
      ctrl2_reg <= CTRL_RST;
      ctrl3_reg <= CTRL_RST;
      evcfg_reg <= EVCFG_RST;
    end
    else
    begin
      if (wr_stb && addr_reg == ADR_CTRL1)
        ctrl1_reg <= byte_in;
      if (wr_stb && addr_reg == ADR_CTRL3)
        ctrl3_reg <= byte_in;
      if (wr_stb && addr_reg == ADR_EVCFG)
        evcfg_reg <= byte_in;
      if (wr_stb && addr_reg == ADR_CTRL2)
        ctrl2_reg <= byte_in;
      else
      begin
        if (boot_done)
          ctrl2_reg.reload_req <= 1'b0;
        if (p_new && oneshot_mode)
          ctrl2_reg.one_shot <= 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      calib_trim <= TRIM_RST;
      init_reg <= 1'b1;
    end
    else
    begin
      init_reg <= 1'b0;
      if (init_reg || boot_done)
        calib_trim <= trim_store;
    end
  end

  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      ref_reg <= 24'h0;
      ths_reg <= 16'h0;
      ofs_reg <= 24'h0;
      az_pend_reg <= 1'b0;
      az_reg <= 1'b0;
    end
    else if (sw_rst)
    begin
      ref_reg <= 24'h0;
      ths_reg <= 16'h0;
      ofs_reg <= 24'h0;
      az_pend_reg <= 1'b0;
      az_reg <= 1'b0;
    end
    else
    begin
      if (wr_stb && addr_reg == ADR_CTRL2)
        az_pend_reg <= byte_in[1];
      else if (p_new && az_pend_reg)
        az_pend_reg <= 1'b0;
      if (!ctrl2_reg.auto_zero)
        az_reg <= 1'b0;
      else if (p_new && az_pend_reg)
        az_reg <= 1'b1;
      if (p_new && az_pend_reg)
        ref_reg <= comp;
      else if (wr_stb && addr_reg == ADR_REF_XL)
        ref_reg[7:0] <= byte_in;
      else if (wr_stb && addr_reg == ADR_REF_L)
        ref_reg[15:8] <= byte_in;
      else if (wr_stb && addr_reg == ADR_REF_H)
        ref_reg[23:16] <= byte_in;
      if (wr_stb && addr_reg == ADR_THS_L)
        ths_reg[7:0] <= byte_in;
      if (wr_stb && addr_reg == ADR_THS_H)
        ths_reg[15:8] <= byte_in;
      if (wr_stb && addr_reg == ADR_OFS_XL)
        ofs_reg[7:0] <= byte_in;
      if (wr_stb && addr_reg == ADR_OFS_L)
        ofs_reg[15:8] <= byte_in;
      if (wr_stb && addr_reg == ADR_OFS_H)
        ofs_reg[23:16] <= byte_in;
    end
  end

  //----------------------------------------------------------------------
  // Outputs, status and interrupt source
  //----------------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      pout_reg <= 24'h0;
      tout_reg <= 16'h0;
      pmask_reg <= 3'h0;
      tmask_reg <= 2'h0;
      {pda_reg, tda_reg, por_reg, tor_reg} <= 4'h0;
      isrc_reg <= 3'h0;
    end
    else if (sw_rst)
    begin
      pout_reg <= 24'h0;
      tout_reg <= 16'h0;
      pmask_reg <= 3'h0;
      tmask_reg <= 2'h0;
      {pda_reg, tda_reg, por_reg, tor_reg} <= 4'h0;
      isrc_reg <= 3'h0;
    end
    else
    begin
      pmask_reg <= pmask_next;
      tmask_reg <= tmask_next;
      if (p_new && !plock)
        pout_reg <= az_pend_reg ? 24'h0 : pout_next;
      if (t_new && !tlock)
        tout_reg <= sensor_temp;
      pda_reg <= p_new || (pda_reg && !rd_ph);
      por_reg <= (p_new && pda_reg) || (por_reg && !rd_ph);
      tda_reg <= t_new || (tda_reg && !rd_th);
      tor_reg <= (t_new && tda_reg) || (tor_reg && !rd_th);
      if (!ctrl1_reg.differential_enable)
        isrc_reg <= 3'h0;
      else if (evcfg_reg.irq_latch_enable)
        isrc_reg <= (eval ? evv : 3'h0) | (rd_isrc ? 3'h0 : isrc_reg);
      else if (eval)
        isrc_reg <= evv;
    end
  end

  //----------------------------------------------------------------------
  // Interrupt pads
  //----------------------------------------------------------------------
  for (genvar i = 0; i < 2; i++)
  begin : g_pad
    logic [2:0] sel;
    logic act, lvl;
    assign sel = (i == 0) ? ctrl3_reg.first_pad_source_sel :
      ctrl3_reg.second_pad_source_sel;
    always_comb
    begin
      case (sel)
        SEL_HIGH: act = isrc_reg[0];
        SEL_LOW: act = isrc_reg[1];
        SEL_EITHER: act = isrc_reg[0] || isrc_reg[1];
        SEL_DRDY: act = pda_reg;
        default: act = 1'b0;
      endcase
      lvl = (sel == SEL_GND) ? 1'b0 : act ^ ctrl3_reg.irq_active_low;
    end
    always_ff @(posedge core_clk or negedge rst_b)
    begin
      if (!rst_b)
      begin
        pad_out_reg[i] <= 1'b0;
        pad_oe_reg[i] <= 1'b0;
      end
      else
      begin
        pad_out_reg[i] <= ctrl3_reg.irq_drive_type ? 1'b0 : lvl;
        pad_oe_reg[i] <= sel != SEL_HIZ &&
          (!ctrl3_reg.irq_drive_type || !lvl);
      end
    end
  end

  assign first_irq_pad_out = pad_out_reg[0];
  assign first_irq_pad_oe = pad_oe_reg[0];
  assign second_irq_pad_out = pad_out_reg[1];
  assign second_irq_pad_oe = pad_oe_reg[1];
  assign power_active = ctrl1_reg.power_active_bit;

  //----------------------------------------------------------------------
  // Checks
  //----------------------------------------------------------------------
  power_down_a: assert property (!ctrl1_reg.power_active_bit |-> !p_new)
    else $error("sample produced in power-down");
  oneshot_done_a: assert property ((p_new && oneshot_mode &&
    !wr_stb && !sw_rst) |=> !ctrl2_reg.one_shot && pda_reg && tda_reg)
    else $error("one-shot completion wrong");
  diff_off_a: assert property (!ctrl1_reg.differential_enable |=>
    isrc_reg == 3'h0)
    else $error("source set while differential off");
  bdu_hold_a: assert property ((plock && !pmask_next[2] && !sw_rst) |=>
    $stable(pout_reg))
    else $error("locked output changed");
  reload_wait_a: assert property ((ctrl2_reg.reload_req &&
    !tick[0] && !wr_stb) |=> ctrl2_reg.reload_req)
    else $error("reload acted early");
  reload_clear_a: assert property ((boot_done && !wr_stb) |=>
    !ctrl2_reg.reload_req && calib_trim == $past(trim_store))
    else $error("reload did not complete");
  open_drain_a: assert property (ctrl3_reg.irq_drive_type ##1
    ctrl3_reg.irq_drive_type |-> !(first_irq_pad_oe && first_irq_pad_out))
    else $error("open drain pad driven high");
  hiz_pad_a: assert property (ctrl3_reg.second_pad_source_sel ==
    SEL_HIZ |=> !second_irq_pad_oe)
    else $error("tri-state pad driven");
  reserved_pad_a: assert property ((ctrl3_reg.first_pad_source_sel
    inside {3'h5, 3'h6} && !ctrl3_reg.irq_drive_type) |=>
    first_irq_pad_out == $past(ctrl3_reg.irq_active_low))
    else $error("reserved source not inactive");
  drdy_pol_a: assert property ((ctrl3_reg.first_pad_source_sel ==
    SEL_DRDY && !ctrl3_reg.irq_drive_type) |=> first_irq_pad_out ==
    ($past(pda_reg) ^ $past(ctrl3_reg.irq_active_low)))
    else $error("data ready level wrong");
  latch_hold_a: assert property ((evcfg_reg.irq_latch_enable &&
    ctrl1_reg.differential_enable && isrc_reg[0] && !rd_isrc &&
    !wr_stb && !sw_rst) |=> isrc_reg[0])
    else $error("latched request lost");
  sim_pin_a: assert property (!ctrl1_reg.three_wire_select |->
    !shared_serial_pin_oe)
    else $error("shared pin driven in 4-wire");
  pda_set_a: assert property (p_new && !sw_rst |=> pda_reg)
    else $error("ready flag not set");
  cover_read_c: cover property (rd_stb ##[1:300] rd_stb);
  cover_oneshot_c: cover property (p_new && oneshot_mode);
  cover_event_c: cover property (eval && evv[2]);
endmodule // psci_top

// ---- rtl/psci_pkg.sv ----
// Constants, register map and types of the pressure control and irq block
//----------------------------------------------------------------------
// What this block does
// - Power control bit 0 after boot keeps power-down; 1 makes device active.
// - Rate field 000 one-shot, 001..111 select the pressure/temperature rates.
// - Differential enable 1 runs threshold and interrupt circuitry; 0 stops it.
// - Block update holds an output until all its bytes were read.
// - Offset enable bit switches the calibration offset registers on or off.
// - Three-wire select 0 reads on serial out pin; 1 on shared pin.
// - Reload bit copies trim store to calibration, then clears itself.
// - Reload takes effect at the next pressure rate tick, at most one output data rate period after being set.
// - Soft reset together with reload restores power-on configuration.
// - Auto-zero captures pressure as reference; output then reads difference.
// - One-shot bit in rate 000 runs one conversion, sets flags, self-clears.
// - Polarity bit 0 makes pads active high, 1 active low.
// - Drive type bit 0 push-pull, 1 open drain on both pads.
// - Per-pad 3-bit source selector: ground, high, low, either, ready, off.
// - Data-ready source shows that a new pressure value is available.
// - Latch enable holds interrupt requests in the source register.
// - Low event enable requests interrupt when difference is below threshold.
// - High event enable requests interrupt when difference is above threshold.
// - Reference is 24-bit two's complement in three bytes, added to output; subtracted from it once auto-zero is active.
// - Threshold is a 16-bit unsigned value in low and high bytes.
// - Pressure ready flag sets on new sample, clears on pressure read.
// - Calibration offset acts on output pressure only when enabled.
//----------------------------------------------------------------------
package psci_pkg;
  //----------------------------------------------------------------------
  // Register offsets
  //----------------------------------------------------------------------
  localparam logic [6:0] ADR_REF_XL = 7'h08, ADR_REF_L = 7'h09;
  localparam logic [6:0] ADR_REF_H = 7'h0a, ADR_ID = 7'h0f;
  localparam logic [6:0] ADR_CTRL1 = 7'h20, ADR_CTRL2 = 7'h21;
  localparam logic [6:0] ADR_CTRL3 = 7'h22, ADR_EVCFG = 7'h23;
  localparam logic [6:0] ADR_ISRC = 7'h24, ADR_THS_L = 7'h25;
  localparam logic [6:0] ADR_THS_H = 7'h26, ADR_STATUS = 7'h27;
  localparam logic [6:0] ADR_POUT_XL = 7'h28, ADR_POUT_L = 7'h29;
  localparam logic [6:0] ADR_POUT_H = 7'h2a, ADR_TOUT_L = 7'h2b;
  localparam logic [6:0] ADR_TOUT_H = 7'h2c, ADR_OFS_XL = 7'h3c;
  localparam logic [6:0] ADR_OFS_L = 7'h3d, ADR_OFS_H = 7'h3e;
  //----------------------------------------------------------------------
  // Reset values and codes
  //----------------------------------------------------------------------
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] EVCFG_RST = 8'h00;
  // Identity value is arbitrary
  localparam logic [7:0] ID_VALUE = 8'h5a;
  localparam logic [15:0] TRIM_RST = 16'h0000;
  localparam logic [2:0] RATE_ONE_SHOT = 3'h0;
  localparam logic [2:0] SEL_GND = 3'h0, SEL_HIGH = 3'h1, SEL_LOW = 3'h2;
  localparam logic [2:0] SEL_EITHER = 3'h3, SEL_DRDY = 3'h4;
  localparam logic [2:0] SEL_HIZ = 3'h7;
  //----------------------------------------------------------------------
  // Timing
  //----------------------------------------------------------------------
  localparam longint CLK_HZ = 125_000_000;
  localparam longint RATE_1HZ_MHZ = 1000, RATE_7HZ_MHZ = 7000;
  localparam longint RATE_12HZ5_MHZ = 12500, RATE_25HZ_MHZ = 25000;
  localparam int PER_1HZ_CYC = int'(CLK_HZ * 1000 / RATE_1HZ_MHZ);
  localparam int PER_7HZ_CYC = int'(CLK_HZ * 1000 / RATE_7HZ_MHZ);
  localparam int PER_12HZ5_CYC = int'(CLK_HZ * 1000 / RATE_12HZ5_MHZ);
  localparam int PER_25HZ_CYC = int'(CLK_HZ * 1000 / RATE_25HZ_MHZ);
  //----------------------------------------------------------------------
  // Types
  //----------------------------------------------------------------------
  typedef struct packed {
    logic power_active_bit;
    logic [2:0] sample_rate_sel;
    logic differential_enable;
    logic block_update;
    logic offset_enable;
    logic three_wire_select;
  } psci_ctrl1_type;
  typedef struct packed {
    logic reload_req;
    logic [3:0] spare;
    logic soft_reset_req;
    logic auto_zero;
    logic one_shot;
  } psci_ctrl2_type;
  typedef struct packed {
    logic irq_active_low;
    logic irq_drive_type;
    logic [2:0] second_pad_source_sel;
    logic [2:0] first_pad_source_sel;
  } psci_ctrl3_type;
  typedef struct packed {
    logic [4:0] spare;
    logic irq_latch_enable;
    logic low_event_enable;
    logic high_event_enable;
  } psci_evcfg_type;
  typedef enum logic [3:0] {
    SPI_IDLE = 4'b0001,
    SPI_CMD = 4'b0010,
    SPI_WR = 4'b0100,
    SPI_RD = 4'b1000
  } psci_spi_state_type;
endpackage

// ---- test/psci_host.sv ----
// Host serial master model for the pressure control block
module psci_host (
  // Clock
  input wire logic core_clk,
  // Serial link
  output logic spi_cs_b,
  output logic spi_clk,
  output logic mosi,
  input wire logic miso
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    spi_cs_b = 1'b1;
    spi_clk = 1'b1;
    mosi = 1'b1;
  end
  // Ten core cycles, half of 160 ns
  task automatic half();
    repeat (10) @(posedge core_clk);
  endtask
  // Command byte then one data byte, mode 3
  task automatic xfer(input logic [7:0] cmd, input logic [7:0] wd,
    output logic [7:0] rd);
    logic [15:0] sh;
    sh = {cmd, wd};
    spi_cs_b <= 1'b0;
    half();
    for (int i = 15; i >= 0; i--)
    begin
      spi_clk <= 1'b0;
      mosi <= sh[i];
      half();
      spi_clk <= 1'b1;
      half();
      if (i < 8)
        rd[i] = miso;
    end
    spi_cs_b <= 1'b1;
    mosi <= ~mosi;
    half();
  endtask
endmodule // psci_host

// ---- test/pressure_sensor_control_irq_bench.sv ----
// Self-checking bench of the pressure control block
module pressure_sensor_control_irq_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk = 1'b0, rst_b = 1'b0, mosi, miso, sdio, cs_b, sck;
  logic three_w = 1'b0;
  logic [23:0] press = 24'h123456;
  logic [15:0] trim = 16'h1111, calib;
  logic sh_o, sh_oe, so, so_oe, pa, p1, p1e, p2, p2e;
  logic [7:0] v;
  int bad_count = 0, samples_checked = 0;
  assign sdio = sh_oe ? sh_o : mosi;
  assign miso = three_w ? sdio : (so_oe ? so : 1'b1);
  initial forever #4 core_clk = ~core_clk;
  psci_host host_u (.core_clk(core_clk), .spi_cs_b(cs_b), .spi_clk(sck),
    .mosi(mosi), .miso(miso));
  psci_top #(.PER_1HZ(400), .PER_7HZ(200), .PER_12HZ5(150), .PER_25HZ(100))
    dut_u (.core_clk(core_clk), .rst_b(rst_b), .spi_cs_b(cs_b),
    .spi_clk(sck), .shared_serial_pin_in(sdio),
    .shared_serial_pin_out(sh_o), .shared_serial_pin_oe(sh_oe),
    .serial_out_pin(so), .serial_out_pin_oe(so_oe), .sensor_press(press),
    .sensor_temp(16'h0abc), .trim_store(trim), .calib_trim(calib),
    .power_active(pa), .first_irq_pad_out(p1), .first_irq_pad_oe(p1e),
    .second_irq_pad_out(p2), .second_irq_pad_oe(p2e));
  task automatic cmp(input logic [7:0] g, input logic [7:0] e);
    samples_checked++;
    if (g !== e)
    begin
      bad_count++;
      $display("Error %0t got %h expected %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    host_u.xfer({2'b00, a[5:0]}, d, v);
  endtask
  task automatic chk(input logic [6:0] a, input logic [7:0] e);
    host_u.xfer({2'b10, a[5:0]}, 8'h00, v);
    cmp(v, e);
  endtask
  task automatic summarize();
    $display("Checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial
  begin
    #400us;
    bad_count++;
    summarize();
  end
  initial
  begin
    repeat (20) @(posedge core_clk);
    rst_b <= 1'b1;
    for (int a = 'h20; a <= 'h23; a++)
      chk(7'(a), 8'h00);
    cmp({7'h0, pa}, 8'h00);
    chk(7'h11, 8'h00);
    $display("Reset test finished");
    for (int k = 0; k < 16; k++)
    begin
      wr(7'h22, {k[3], 1'b0, k[2:0], k[2:0]});
      v = {6'h0, k[3] && k[2:0] != 3'h0 && k[2:0] != 3'h7, k[2:0] != 3'h7};
      cmp({6'h0, p1 & p1e, p1e}, v);
      cmp({6'h0, p2 & p2e, p2e}, v);
    end
    wr(7'h22, 8'hed);
    cmp({7'h0, p1e}, 8'h00);
    $display("Pad test finished");
    wr(7'h22, 8'h04);
    wr(7'h20, 8'h80);
    cmp({7'h0, pa}, 8'h01);
    wr(7'h21, 8'h01);
    repeat (150) @(posedge core_clk);
    cmp({7'h0, p1}, 8'h01);
    chk(7'h21, 8'h00);
    chk(7'h27, 8'h03);
    chk(7'h28, 8'h56);
    chk(7'h29, 8'h34);
    chk(7'h2a, 8'h12);
    chk(7'h27, 8'h01);
    $display("One-shot test finished");
    trim <= 16'hbeef;
    wr(7'h21, 8'h80);
    repeat (120) @(posedge core_clk);
    cmp(calib[7:0], 8'hef);
    cmp(calib[15:8], 8'hbe);
    chk(7'h21, 8'h00);
    wr(7'h20, 8'h81);
    three_w <= 1'b1;
    chk(7'h20, 8'h81);
    wr(7'h23, 8'h07);
    wr(7'h21, 8'h84);
    repeat (120) @(posedge core_clk);
    three_w <= 1'b0;
    chk(7'h23, 8'h00);
    chk(7'h20, 8'h00);
    $display("Reload and reset test finished");
    wr(7'h0a, 8'h12);
    wr(7'h25, 8'h10);
    wr(7'h22, 8'h01);
    wr(7'h23, 8'h05);
    wr(7'h20, 8'h8c);
    wr(7'h21, 8'h01);
    repeat (120) @(posedge core_clk);
    cmp({7'h0, p1}, 8'h01);
    chk(7'h24, 8'h05);
    chk(7'h24, 8'h00);
    chk(7'h2a, 8'h24);
    press <= 24'h654321;
    wr(7'h21, 8'h01);
    repeat (120) @(posedge core_clk);
    chk(7'h28, 8'h56);
    chk(7'h29, 8'h34);
    $display("Differential and block update test finished");
    summarize();
  end
endmodule // pressure_sensor_control_irq_bench
